// ### flash_ctrl.sv
// host-side controller that runs status, lock, erase and program sequences on a NOR flash

// Notes on behaviour
// - only defined command codes are ever sent; unknown operations are refused.
// - completion is found by polling status bit 7.
// - status bits 6 to 1 are taken only when ready reads one.
// - reserved status bits 15 to 8 and 0 are masked on every poll.
module flash_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int ADDR_W = FLASH_ADDR_W
)
(
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire flash_ctrl_pkg::sw_req_s       sw_req,
    output      logic [31:0]                   sw_rdata,
    output      flash_ctrl_pkg::flash_pins_s   flash_pins,
    input  wire logic [FLASH_DATA_W-1:0]       flash_dq_in,
    input  wire logic                          ready_busy_status_pin
);
    import flash_ctrl_pkg::*;

    if (ADDR_W != FLASH_ADDR_W)
    begin : g_bad_width
        $error("flash_ctrl: ADDR_W must equal the pin struct address width");
    end

    // ************************************************************
    // types and signals
    // ************************************************************
    typedef enum logic [6:0] {
        S_IDLE     = 7'b0000001,
        S_FETCH    = 7'b0000010,
        S_WR_SETUP = 7'b0000100,
        S_WR_LOW   = 7'b0001000,
        S_WR_HIGH  = 7'b0010000,
        S_RD_LOW   = 7'b0100000,
        S_NEXT     = 7'b1000000
    } state_e;

    state_e                  state;
    logic [7:0]              cnt;
    logic [1:0]              idx;
    logic [3:0]              cur_op;
    logic                    busy;
    logic                    refused;
    logic [ADDR_W-1:0]       op_addr;
    logic [FLASH_DATA_W-1:0] op_data;
    logic [FLASH_DATA_W-1:0] dq_meta;
    logic [FLASH_DATA_W-1:0] dq_sync;
    logic                    pin_meta;
    logic                    pin_sync;
    logic [FLASH_DATA_W-1:0] rd_word;
    logic [FLASH_DATA_W-1:0] last_status;
    logic [FLASH_DATA_W-1:0] result;
    step_s                   step;
    logic                    start;

    // ************************************************************
    // operation programs
    // ************************************************************
    function automatic step_s mk(act_e act, logic [7:0] code, logic use_data);
        step_s s;
        s.act      = act;
        s.code     = code;
        s.use_data = use_data;
        return s;
    endfunction

    function automatic step_s step_of(logic [3:0] op, logic [1:0] i);
        step_s s;
        s = mk(ACT_END, 8'h00, 1'b0);
        unique case (op)
            OP_ERASE:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_ERASE_SETUP, 1'b0);
                else if (i == 2'd1) s = mk(ACT_WRITE, CODE_CONFIRM, 1'b0);
                else if (i == 2'd2) s = mk(ACT_POLL, 8'h00, 1'b0);
            OP_PROGRAM:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_PROG_SETUP, 1'b0);
                else if (i == 2'd1) s = mk(ACT_WRITE, 8'h00, 1'b1);
                else if (i == 2'd2) s = mk(ACT_POLL, 8'h00, 1'b0);
            OP_SET_LOCK:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_LOCK_SETUP, 1'b0);
                else if (i == 2'd1) s = mk(ACT_WRITE, CODE_LOCK_SET, 1'b0);
                else if (i == 2'd2) s = mk(ACT_POLL, 8'h00, 1'b0);
            OP_CLEAR_LOCK:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_LOCK_SETUP, 1'b0);
                else if (i == 2'd1) s = mk(ACT_WRITE, CODE_CONFIRM, 1'b0);
                else if (i == 2'd2) s = mk(ACT_POLL, 8'h00, 1'b0);
            OP_SUSPEND:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_SUSPEND, 1'b0);
                else if (i == 2'd1) s = mk(ACT_POLL, 8'h00, 1'b0);
            OP_RESUME:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_CONFIRM, 1'b0);
                else if (i == 2'd1) s = mk(ACT_POLL, 8'h00, 1'b0);
            OP_CLEAR_STATUS:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_CLEAR_STATUS, 1'b0);
            OP_READ_STATUS:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_READ_STATUS, 1'b0);
                else if (i == 2'd1) s = mk(ACT_POLL, 8'h00, 1'b0);
            // lock location read, then back to array
            OP_READ_LOCK:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_READ_ID, 1'b0);
                else if (i == 2'd1) s = mk(ACT_READ, 8'h00, 1'b0);
                else if (i == 2'd2) s = mk(ACT_WRITE, CODE_READ_ARRAY, 1'b0);
            OP_READ_ARRAY:
                if (i == 2'd0) s = mk(ACT_WRITE, CODE_READ_ARRAY, 1'b0);
                else if (i == 2'd1) s = mk(ACT_READ, 8'h00, 1'b0);
            default:
                s = mk(ACT_END, 8'h00, 1'b0);
        endcase
        return s;
    endfunction

    function automatic logic op_known(logic [3:0] op);
        return (op >= OP_ERASE) && (op <= OP_READ_ARRAY);
    endfunction

    always_comb
    begin
        step  = step_of(cur_op, idx);
        start = sw_req.wr && (sw_req.addr == REG_CTRL) && !busy
                && op_known(sw_req.wdata[3:0]);
    end

    // ************************************************************
    // input synchronisers
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dq_meta  <= 16'h0000;
            dq_sync  <= 16'h0000;
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            dq_meta  <= flash_dq_in;
            dq_sync  <= dq_meta;
            pin_meta <= ready_busy_status_pin;
            pin_sync <= pin_meta;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state  <= S_IDLE;
            cnt    <= 8'h00;
            idx    <= 2'd0;
            cur_op <= 4'h0;
            busy   <= 1'b0;
        end
        else
        begin
            unique case (state)
                S_IDLE:
                    if (start)
                    begin
                        cur_op <= sw_req.wdata[3:0];
                        idx    <= 2'd0;
                        busy   <= 1'b1;
                        state  <= S_FETCH;
                    end
                S_FETCH:
                    unique case (step.act)
                        ACT_WRITE: state <= S_WR_SETUP;
                        ACT_READ,
                        ACT_POLL:
                        begin
                            cnt   <= 8'(READ_CYC);
                            state <= S_RD_LOW;
                        end
                        ACT_END:
                        begin
                            busy  <= 1'b0;
                            state <= S_IDLE;
                        end
                    endcase
                S_WR_SETUP:
                begin
                    cnt   <= 8'(WE_LOW_CYC);
                    state <= S_WR_LOW;
                end
                S_WR_LOW:
                    if (cnt == 8'h01)
                    begin
                        cnt   <= 8'(WE_HIGH_CYC);
                        state <= S_WR_HIGH;
                    end
                    else
                        cnt <= cnt - 8'h01;
                S_WR_HIGH:
                    if (cnt == 8'h01)
                    begin
                        idx   <= idx + 2'd1;
                        state <= S_FETCH;
                    end
                    else
                        cnt <= cnt - 8'h01;
                S_RD_LOW:
                    if (cnt == 8'h01)
                        state <= S_NEXT;
                    else
                        cnt <= cnt - 8'h01;
                S_NEXT:
                begin
                    if (step.act != ACT_POLL || rd_word[BIT_READY])
                        idx <= idx + 2'd1;
                    state <= S_FETCH;
                end
            endcase
        end
    end

    // ************************************************************
    // flash pins
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            flash_pins <= '{addr: '0, dq_out: 16'h0000, dq_oe: 1'b0, chip_en_n: 1'b1,
                            out_en_n: 1'b1, write_en_n: 1'b1, reset_n: 1'b0};
        end
        else
        begin
            flash_pins.reset_n <= 1'b1;
            if (state == S_FETCH && step.act == ACT_WRITE)
            begin
                flash_pins.addr      <= op_addr;
                flash_pins.dq_out    <= step.use_data ? op_data : {8'h00, step.code};
                flash_pins.dq_oe     <= 1'b1;
                flash_pins.chip_en_n <= 1'b0;
            end
            else if (state == S_FETCH && step.act != ACT_END)
            begin
                flash_pins.addr      <= op_addr;
                flash_pins.chip_en_n <= 1'b0;
                flash_pins.out_en_n  <= 1'b0;
            end
            else if (state == S_WR_SETUP)
                flash_pins.write_en_n <= 1'b0;
            else if (state == S_WR_LOW && cnt == 8'h01)
                flash_pins.write_en_n <= 1'b1;
            else if ((state == S_WR_HIGH || state == S_RD_LOW) && cnt == 8'h01)
            begin
                flash_pins.dq_oe     <= 1'b0;
                flash_pins.chip_en_n <= 1'b1;
                flash_pins.out_en_n  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // captured words
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_word     <= 16'h0000;
            last_status <= 16'h0000;
            result      <= 16'h0000;
        end
        else
        begin
            if (state == S_RD_LOW && cnt == 8'h01)
                rd_word <= dq_sync;
            if (state == S_NEXT && step.act == ACT_READ)
                result <= rd_word;
            // error and suspend bits kept only when ready
            if (state == S_NEXT && step.act == ACT_POLL && rd_word[BIT_READY])
                last_status <= rd_word & STATUS_VALID_MASK;
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            op_addr  <= '0;
            op_data  <= 16'h0000;
            refused  <= 1'b0;
            sw_rdata <= 32'h0000_0000;
        end
        else
        begin
            if (sw_req.wr && !busy && sw_req.addr == REG_ADDR)
                op_addr <= sw_req.wdata[ADDR_W-1:0];
            if (sw_req.wr && !busy && sw_req.addr == REG_DATA)
                op_data <= sw_req.wdata[FLASH_DATA_W-1:0];
            if (sw_req.wr && sw_req.addr == REG_CTRL)
                refused <= !start;
            sw_rdata <= 32'h0000_0000;
            if (sw_req.rd)
            begin
                unique case (sw_req.addr)
                    REG_CTRL:   sw_rdata <= {26'h0, refused, busy, cur_op};
                    REG_ADDR:   sw_rdata <= 32'(op_addr);
                    REG_DATA:   sw_rdata <= {16'h0000, op_data};
                    REG_STATUS: sw_rdata <= {22'h0, pin_sync, busy, last_status[7:0]};
                    REG_RESULT: sw_rdata <= {16'h0000, result};
                    default:    sw_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // flash_ctrl

// ### flash_ctrl_pkg.sv
// constants and carrier types for the status and block-lock flash controller
package flash_ctrl_pkg;

    // ************************************************************
    // widths and timing
    // ************************************************************
    localparam int FLASH_ADDR_W  = 22;
    localparam int FLASH_DATA_W  = 16;
    localparam int SW_ADDR_W     = 8;
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_WE_LOW_NS   = 60;
    localparam int T_WE_HIGH_NS  = 30;
    localparam int T_READ_ACC_NS = 100;
    localparam int SYNC_STAGES   = 2;
    localparam int WE_LOW_CYC    = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_HIGH_CYC   = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC      = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                   + SYNC_STAGES;

    // ************************************************************
    // command codes sent to the flash
    // ************************************************************
    localparam logic [7:0] CODE_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CODE_READ_ID      = 8'h90;
    localparam logic [7:0] CODE_READ_STATUS  = 8'h70;
    localparam logic [7:0] CODE_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CODE_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CODE_CONFIRM      = 8'hD0;
    localparam logic [7:0] CODE_PROG_SETUP   = 8'h40;
    localparam logic [7:0] CODE_SUSPEND      = 8'hB0;
    localparam logic [7:0] CODE_LOCK_SETUP   = 8'h60;
    localparam logic [7:0] CODE_LOCK_SET     = 8'h01;

    // ************************************************************
    // status word layout
    // ************************************************************
    localparam int BIT_READY         = 7;
    localparam int BIT_ERASE_SUSP    = 6;
    localparam int BIT_ERASE_ERR     = 5;
    localparam int BIT_PROG_ERR      = 4;
    localparam int BIT_VOLT_LOW      = 3;
    localparam int BIT_PROG_SUSP     = 2;
    localparam int BIT_LOCK_VIOL     = 1;
    localparam int BIT_LOCK_STATE    = 0;
    localparam logic [15:0] STATUS_VALID_MASK = 16'h00FE;

    // ************************************************************
    // software register map and operation codes
    // ************************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RESULT = 8'h10;

    localparam logic [3:0] OP_ERASE        = 4'h1;
    localparam logic [3:0] OP_PROGRAM      = 4'h2;
    localparam logic [3:0] OP_SET_LOCK     = 4'h3;
    localparam logic [3:0] OP_CLEAR_LOCK   = 4'h4;
    localparam logic [3:0] OP_SUSPEND      = 4'h5;
    localparam logic [3:0] OP_RESUME       = 4'h6;
    localparam logic [3:0] OP_CLEAR_STATUS = 4'h7;
    localparam logic [3:0] OP_READ_STATUS  = 4'h8;
    localparam logic [3:0] OP_READ_LOCK    = 4'h9;
    localparam logic [3:0] OP_READ_ARRAY   = 4'hA;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef enum logic [1:0] {ACT_WRITE, ACT_READ, ACT_POLL, ACT_END} act_e;

    typedef struct packed {
        act_e       act;
        logic [7:0] code;
        logic       use_data;
    } step_s;

    typedef struct packed {
        logic [FLASH_ADDR_W-1:0] addr;
        logic [FLASH_DATA_W-1:0] dq_out;
        logic                    dq_oe;
        logic                    chip_en_n;
        logic                    out_en_n;
        logic                    write_en_n;
        logic                    reset_n;
    } flash_pins_s;

    typedef struct packed {
        logic [SW_ADDR_W-1:0] addr;
        logic [31:0]          wdata;
        logic                 wr;
        logic                 rd;
    } sw_req_s;

endpackage // flash_ctrl_pkg

// ### flash_ctrl_properties.sv
// checker on the flash controller ports
module flash_ctrl_properties
    import flash_ctrl_pkg::*;
(
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire flash_ctrl_pkg::sw_req_s     sw_req,
    input wire logic [31:0]                 sw_rdata,
    input wire flash_ctrl_pkg::flash_pins_s flash_pins,
    input wire logic [FLASH_DATA_W-1:0]     flash_dq_in,
    input wire logic                        ready_busy_status_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // bus timing
    // ****************
    wire logic we_n = flash_pins.write_en_n;
    wire logic oe_n = flash_pins.out_en_n;
    wire logic ce_n = flash_pins.chip_en_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_we_low_len: assert property ($fell(we_n) |-> (!we_n)[*8] ##1 (!we_n)[*4] ##1 we_n)
        else $error("write strobe width wrong");
    a_we_ce_hold: assert property ($rose(we_n) && !ce_n |-> (!ce_n)[*6] ##1 ce_n)
        else $error("chip enable hold wrong");
    a_read_len: assert property ($fell(oe_n) |-> (!oe_n)[*8] ##1 (!oe_n)[*8] ##1 (!oe_n)[*6] ##1 oe_n)
        else $error("read strobe width wrong");
    a_strobes_excl: assert property (!(!oe_n && !we_n))
        else $error("read and write strobes overlap");
    a_we_framed: assert property (!we_n |-> !ce_n && flash_pins.dq_oe
        && $stable(flash_pins.dq_out) && $stable(flash_pins.addr))
        else $error("write cycle not framed");
    a_oe_released: assert property (!oe_n |-> !flash_pins.dq_oe)
        else $error("data driven during read");
    a_rdata_idle: assert property (!$past(sw_req.rd) |-> sw_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_status_masked: assert property ($past(sw_req.rd) && $past(sw_req.addr) == REG_STATUS
        |-> sw_rdata[31:10] == 22'h0 && !sw_rdata[0])
        else $error("reserved status bits leak");
    a_reset_pins: assert property (disable iff (1'b0) rst |-> !flash_pins.reset_n && we_n
        && !flash_pins.dq_oe) else $error("pins not quiet in reset");
    cover property ($fell(we_n));
    cover property ($fell(oe_n));
    cover property ($past(sw_req.rd) && $past(sw_req.addr) == REG_STATUS);
endmodule // flash_ctrl_properties

bind flash_ctrl flash_ctrl_properties i_props (.ref_clk, .rst, .sw_req, .sw_rdata, .flash_pins,
    .flash_dq_in, .ready_busy_status_pin);

// ### flash_model.sv
// behavioural flash device: status word and block locks
module flash_model
    import flash_ctrl_pkg::*;
#(
    parameter int BUSY_CYC = 60
)
(
    input  wire logic                        ref_clk,
    input  wire flash_ctrl_pkg::flash_pins_s pins,
    input  wire logic                        volt_low,
    output      logic [15:0]                 dq,
    output      logic                        sts
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // command engine
    // ****************
    logic [63:0] lock = 64'h0;
    logic [7:0]  prev = 8'h00;
    logic [6:1]  sr   = 6'h00;
    logic [1:0]  mode = 2'h0;
    logic        kind = 1'b0;
    logic        we_q = 1'b1;
    logic [15:0] last = 16'h0000;
    int          busy = 0;
    wire  [5:0]  blk  = pins.addr[21:16];
    wire  [7:0]  c    = pins.dq_out[7:0];
    task automatic start(input logic prog);
        if (volt_low) begin sr[3] <= 1'b1; sr[prog ? 4 : 5] <= 1'b1; end
        else if (lock[blk]) begin sr[1] <= 1'b1; sr[prog ? 4 : 5] <= 1'b1; end
        else begin busy <= BUSY_CYC; kind <= prog; end
    endtask
    always @(posedge ref_clk)
    begin
        we_q <= pins.write_en_n;
        last <= dq;
        if (busy > 0) busy <= busy - 1;
        if (!pins.reset_n) begin mode <= 2'h0; sr <= 6'h00; busy <= 0; prev <= 8'h00; end
        else if (!we_q && pins.write_en_n && !pins.chip_en_n)
        begin
            prev <= 8'h00;
            mode <= 2'h2;
            if (prev == 8'h20) begin if (c == 8'hD0) start(1'b0); else sr[5:4] <= 2'b11; end
            else if (prev == 8'h40) start(1'b1);
            else if (prev == 8'h60)
            begin
                if (c == 8'h01) lock[blk] <= 1'b1;
                else if (c == 8'hD0) lock <= 64'h0;
                else sr[5:4] <= 2'b11;
            end
            else case (c)
                8'hFF: mode <= 2'h0;
                8'h90: mode <= 2'h1;
                8'h70: mode <= 2'h2;
                8'h50: begin sr[5:3] <= 3'h0; sr[1] <= 1'b0; end
                8'h20, 8'h40, 8'h60: prev <= c;
                8'hB0: if (busy > 0) begin busy <= 0; sr[kind ? 2 : 6] <= 1'b1; end
                8'hD0: if (sr[2]) begin sr[2] <= 1'b0; busy <= BUSY_CYC; kind <= 1'b1; end
                       else if (sr[6]) begin sr[6] <= 1'b0; busy <= BUSY_CYC; kind <= 1'b0; end
                8'hE8: mode <= 2'h3;
                default: sr[5:4] <= 2'b11;
            endcase
        end
    end
    always @*
    begin
        if (pins.chip_en_n || pins.out_en_n) dq = ~last;
        else if (mode == 2'h0) dq = pins.addr[15:0] ^ 16'h5A5A;
        else if (mode == 2'h1) dq = {15'h0000, lock[blk]};
        // upper byte reserved, bit 7 buffer free
        else if (mode == 2'h3) dq = {8'h00, busy == 0, 7'h00};
        else dq = {8'hA5, busy == 0, sr, 1'b1};
    end
    assign sts = (busy == 0);
endmodule // flash_model

// ### test_flash_status_and_block_lock.sv
// self-checking bench for the flash status and block-lock controller
module test_flash_status_and_block_lock;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_ctrl_pkg::*;
    // ****************
    // harness
    // ****************
    logic                        ref_clk = 1'b0;
    logic                        rst;
    logic                        volt_low;
    sw_req_s                     sw_req;
    logic [31:0]                 sw_rdata;
    flash_pins_s                 flash_pins;
    logic [15:0]                 flash_dq_in;
    logic                        ready_busy_status_pin;
    logic [31:0]                 lfsr = 32'h9CF4;
    logic [31:0]                 d;
    logic [31:0]                 a;
    logic [5:0]                  b1;
    int                          fails = 0;
    int                          comparisons = 0;
    initial forever #2.5 ref_clk = ~ref_clk;
    flash_ctrl i_dut (.ref_clk, .rst, .sw_req, .sw_rdata, .flash_pins, .flash_dq_in,
        .ready_busy_status_pin);
    flash_model i_flash (.ref_clk, .pins(flash_pins), .volt_low, .dq(flash_dq_in),
        .sts(ready_busy_status_pin));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin fails++; $display("[ERR] %s exp %h seen %h", nm, exp, seen); end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        sw_req <= '{ad, wd, 1'b1, 1'b0};
        @(posedge ref_clk);
        sw_req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
        sw_req <= '{ad, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        sw_req.rd <= 1'b0;
        #1 rv = sw_rdata;
        @(posedge ref_clk);
    endtask
    task automatic op(input logic [3:0] o);
        logic [31:0] v;
        wr(REG_CTRL, {28'h0, o});
        for (int i = 0; i < 3000; i++) begin rd(REG_CTRL, v); if (v[4] === 1'b0) break; end
        chk("op idle", {31'h0, v[4]}, 32'h0);
    endtask
    task automatic stat(input string nm, input logic [7:0] e);
        logic [31:0] v;
        rd(REG_STATUS, v);
        chk(nm, v, {22'h0, 2'b10, e});
    endtask
    task automatic lock_of(input logic [5:0] b, input logic e);
        logic [31:0] v;
        wr(REG_ADDR, {10'h0, b, 16'h0002});
        op(OP_READ_LOCK);
        rd(REG_RESULT, v);
        chk("lock bit", {31'h0, v[0]}, {31'h0, e});
    endtask
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin #400000; fails++; end_sim(); end
    initial
    begin
        rst = 1'b0;
        volt_low = 1'b0;
        sw_req = '0;
        // real rising edge so the asynchronous reset fires before the first clock
        #1 rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        chk("reset pins", {28'h0, flash_pins.reset_n, flash_pins.write_en_n, flash_pins.dq_oe,
            flash_pins.chip_en_n}, 32'h5);
        rst <= 1'b0;
        @(posedge ref_clk);
        a = rnd();
        wr(REG_ADDR, a);
        rd(REG_ADDR, d);
        chk("addr reg", d, {10'h0, a[21:0]});
        a = rnd();
        wr(REG_DATA, a);
        rd(REG_DATA, d);
        chk("data reg", d, {16'h0, a[15:0]});
        rd(8'h14, d);
        chk("unmapped", d, 32'h0);
        for (int k = 0; k < 2; k++) begin wr(REG_CTRL, k ? 32'h0 : 32'hB); rd(REG_CTRL, d);
            chk("refused", {31'h0, d[5]}, 32'h1); end
        op(OP_CLEAR_STATUS);
        rd(REG_CTRL, d);
        chk("refused clear", {31'h0, d[5]}, 32'h0);
        op(OP_READ_STATUS);
        stat("idle status", 8'h80);
        $display("test registers done");
        a = rnd();
        b1 = a[5:0];
        wr(REG_ADDR, {10'h0, b1, 16'h0002});
        op(OP_SET_LOCK);
        lock_of(b1, 1'b1);
        lock_of(b1 ^ 6'h01, 1'b0);
        wr(REG_ADDR, {10'h0, b1, a[31:16]});
        op(OP_ERASE);
        stat("locked erase", 8'hA2);
        op(OP_PROGRAM);
        stat("errors held", 8'hB2);
        op(OP_CLEAR_STATUS);
        op(OP_READ_STATUS);
        stat("cleared", 8'h80);
        $display("test lock protection done");
        wr(REG_ADDR, {10'h0, b1 ^ 6'h01, 16'h0002});
        op(OP_SET_LOCK);
        op(OP_CLEAR_LOCK);
        lock_of(b1, 1'b0);
        lock_of(b1 ^ 6'h01, 1'b0);
        volt_low <= 1'b1;
        op(OP_PROGRAM);
        stat("low voltage", 8'h98);
        volt_low <= 1'b0;
        op(OP_CLEAR_STATUS);
        op(OP_ERASE);
        stat("erase ok", 8'h80);
        op(OP_SUSPEND);
        op(OP_RESUME);
        stat("resume idle", 8'h80);
        wr(REG_ADDR, {10'h0, a[21:0]});
        op(OP_READ_ARRAY);
        rd(REG_RESULT, d);
        chk("array read", d, {16'h0, a[15:0] ^ 16'h5A5A});
        $display("test operations done");
        op(OP_SET_LOCK);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        lock_of(a[21:16], 1'b1);
        op(OP_READ_STATUS);
        stat("after reset", 8'h80);
        $display("test reset done");
        end_sim();
    end
endmodule // test_flash_status_and_block_lock
